// [rtl/isr_status.sv]
// Status byte, event flags, masks, service request and output queue front end.
`timescale 1ns/1ps
`include "isr_defs.svh"
module isr_status (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       service_mask_wr,
    input  wire logic [7:0] service_mask_wdata,
    input  wire logic       event_mask_wr,
    input  wire logic [7:0] event_mask_wdata,
    input  wire logic       event_read,
    input  wire logic       clear_status,
    input  wire logic       opc_arm,
    input  wire logic       ops_pending,
    input  wire logic       device_error,
    input  wire logic       execution_error,
    input  wire logic       command_error,
    input  wire logic       response_pending,
    input  wire logic       queue_flush,
    input  wire logic       resp_in_valid,
    input  wire logic [7:0] resp_in_data,
    input  wire logic       resp_in_end,
    input  wire logic       resp_out_ready,
    output logic            resp_in_ready,
    output logic            resp_out_valid,
    output logic [7:0]      resp_out_data,
    output logic            resp_out_end,
    output logic            service_request,
    output logic [7:0]      status_poll_byte,
    output logic [7:0]      status_query_byte,
    output logic [7:0]      service_mask_q,
    output logic [7:0]      event_mask_q,
    output logic [15:0]     event_flags_q,
    output logic [15:0]     event_read_data
);
    // Internal storage and its next values.
    logic [7:0]              sre_reg;       // Service request mask.
    logic [7:0]              ese_reg;       // Standard event mask.
    logic [15:0]             evt_reg;       // Sticky standard event flags.
    logic [15:0]             evt_next;      // Flags after this edge.
    logic [15:0]             evt_set;       // Events raised this cycle.
    logic [15:0]             rdat_reg;      // Flags captured by an event read.
    logic [7:0]              poll_reg;      // Status byte, poll view.
    logic [7:0]              query_reg;     // Status byte, query view.
    logic [7:0]              stb_next;      // Status byte before the flop.
    logic                    srq_reg;       // SRQ line drive.
    logic                    ov_reg;        // Output stage holds a byte.
    isr_pkg::isr_entry_t     od_reg;        // Output stage entry.
    isr_pkg::isr_opc_state_t opc_reg;       // Operation complete monitor.
    isr_pkg::isr_opc_state_t opc_next;      // Monitor state after this edge.

    // Queue carrier and the queue itself.
    isr_queue_if #(.WIDTH(`ISR_Q_WIDTH)) qif ();

    isr_fifo #(
        .WIDTH (`ISR_Q_WIDTH),
        .DEPTH (`ISR_Q_DEPTH)
    ) u_queue (
        .clk     (clk),
        .reset_n (reset_n),
        .q       (qif)
    );

    // Formatter side: entries go straight into the queue.
    assign qif.push_valid = resp_in_valid; // see R16
    assign qif.push_data  = {resp_in_end, resp_in_data};
    assign qif.flush      = queue_flush;

    // Output stage: reloads when empty or when the controller takes the byte.
    wire stage_free = !ov_reg || resp_out_ready;
    wire stage_load = qif.pop_valid && stage_free;
    assign qif.pop_ready = stage_free; // see R17

    // Unread data exists anywhere along the queue path.
    wire msg_avail = ov_reg || qif.pop_valid; // see R01

    // A read with nothing held and nothing on its way.
    wire empty_read = resp_out_ready && !msg_avail && !response_pending;
    // A flush that throws away queued or arriving bytes.
    wire data_lost = queue_flush && (msg_avail || resp_in_valid);

    // Summary of enabled standard events.
    wire event_summary_flag = |(evt_reg[7:0] & ese_reg); // see R02

    // Status byte without the request bit, only the used bits.
    wire [7:0] stb_low = ({3'h0, event_summary_flag, msg_avail, 3'h0} << 1) & `ISR_STB_USED;

    // Master summary: any enabled reason, the request bit excluded.
    wire master_summary_flag = |(stb_low & sre_reg & `ISR_SRE_SUMMARY); // see R07

    // Operation complete fires once the armed monitor sees no pending work.
    wire opc_done = (opc_reg == isr_pkg::ISR_OPC_ARMED) && !ops_pending;

    // Events raised this cycle, one per flag position.
    always_comb begin
        evt_set = 16'h0000;
        evt_set[`ISR_EVT_OPC] = opc_done;                  // see R09
        evt_set[`ISR_EVT_QYE] = empty_read || data_lost;   // see R10
        evt_set[`ISR_EVT_DDE] = device_error;              // see R11
        evt_set[`ISR_EVT_EXE] = execution_error;           // see R12
        evt_set[`ISR_EVT_CME] = command_error;             // see R13
    end

    // A read or clear empties the flags, but a new event in that cycle survives.
    wire evt_clear = event_read || clear_status;
    assign evt_next = ((evt_clear ? 16'h0000 : evt_reg) | evt_set)
                    & `ISR_EVT_USED; // see R20

    // Status byte: poll and query views share one value, so bit 6 matches.
    assign stb_next = stb_low | ({7'h00, master_summary_flag} << `ISR_STB_RQS); // see R03 see R06

    // Monitor transitions; a status clear disarms it.
    always_comb begin
        case (opc_reg)
            isr_pkg::ISR_OPC_IDLE: begin
                opc_next = opc_arm ? isr_pkg::ISR_OPC_ARMED : isr_pkg::ISR_OPC_IDLE;
            end
            isr_pkg::ISR_OPC_ARMED: begin
                opc_next = (opc_done || clear_status) ? isr_pkg::ISR_OPC_IDLE
                                                      : isr_pkg::ISR_OPC_ARMED;
            end
            default: begin
                opc_next = isr_pkg::ISR_OPC_IDLE;
            end
        endcase
    end

    // Monitor state register.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            opc_reg <= isr_pkg::ISR_OPC_IDLE;
        end else begin
            opc_reg <= opc_next;
        end
    end

    // Masks written by the controller.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sre_reg <= `ISR_SRE_RESET;
            ese_reg <= `ISR_ESE_RESET;
        end else begin
            if (service_mask_wr) begin
                sre_reg <= service_mask_wdata; // see R05
            end
            if (event_mask_wr) begin
                ese_reg <= event_mask_wdata; // see R15
            end
        end
    end

    // Event flags; reset loads the power on flag, since reset marks power-up.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            evt_reg  <= `ISR_EVT_RESET; // see R14
            rdat_reg <= 16'h0000;
        end else begin
            evt_reg <= evt_next;
            if (event_read) begin
                rdat_reg <= evt_reg;
            end
        end
    end

    // Status byte views and SRQ; they trail their causes by one cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            poll_reg  <= 8'h00;
            query_reg <= 8'h00;
            srq_reg   <= 1'b0;
        end else begin
            poll_reg  <= stb_next; // see R08
            query_reg <= stb_next; // see R08
            srq_reg   <= master_summary_flag;      // see R04
        end
    end

    // Output stage register; a flush drops the byte it holds.
    always_ff @(posedge clk) begin
        if (!reset_n || queue_flush) begin
            ov_reg <= 1'b0;
            od_reg <= 9'h000;
        end else if (stage_load) begin
            ov_reg <= 1'b1;
            od_reg <= qif.pop_data;
        end else if (resp_out_ready) begin
            ov_reg <= 1'b0;
        end
    end

    // Every output comes from a flop.
    assign resp_in_ready     = qif.push_ready;
    assign resp_out_valid    = ov_reg;
    assign resp_out_data     = od_reg[7:0];
    assign resp_out_end      = od_reg[8];
    assign service_request   = srq_reg;
    assign status_poll_byte  = poll_reg;
    assign status_query_byte = query_reg;
    assign service_mask_q    = sre_reg;
    assign event_mask_q      = ese_reg;
    assign event_flags_q     = evt_reg;
    assign event_read_data   = rdat_reg;

    // Checks on the logic above, all on the one clock.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_mav_empty_low: assert property ( // see R01
        (!msg_avail && !resp_in_valid) |=> !status_poll_byte[`ISR_STB_MAV])
        else $error("Message available set with an empty queue.");

    a_mav_held_high: assert property ( // see R01
        (ov_reg && !resp_out_ready && !queue_flush) |=> status_poll_byte[`ISR_STB_MAV])
        else $error("Message available low while a byte waits.");

    a_esb_or_mask: assert property ( // see R02
        status_poll_byte[`ISR_STB_ESB] == $past(|(evt_reg[7:0] & ese_reg)))
        else $error("Event summary does not match the enabled flags.");

    a_srq_rqs_pair: assert property ( // see R03
        service_request == status_poll_byte[`ISR_STB_RQS])
        else $error("SRQ line and request bit disagree.");

    a_srq_cause: assert property ( // see R04
        (msg_avail && sre_reg[`ISR_STB_MAV]) |=> service_request)
        else $error("Enabled message available raised no SRQ.");

    a_mask_store: assert property ( // see R05
        service_mask_wr |=> (service_mask_q == $past(service_mask_wdata)))
        else $error("Service request mask not stored.");

    a_views_equal: assert property ( // see R06
        status_poll_byte == status_query_byte)
        else $error("Poll and query views of the status byte differ.");

    a_mss_reason: assert property ( // see R07
        status_query_byte[`ISR_STB_RQS] |-> $past(|(stb_low & sre_reg)))
        else $error("Master summary set without an enabled reason.");

    a_opc_armed: assert property ( // see R09
        $rose(event_flags_q[`ISR_EVT_OPC]) |-> $past(opc_reg == isr_pkg::ISR_OPC_ARMED))
        else $error("Operation complete set without arming.");

    a_qye_empty: assert property ( // see R10
        empty_read |=> event_flags_q[`ISR_EVT_QYE])
        else $error("Empty read did not flag a query error.");

    a_error_flags: assert property ( // see R11
        device_error |=> event_flags_q[`ISR_EVT_DDE])
        else $error("Device error lost.");

    a_exe_set: assert property ( // see R12
        execution_error |=> event_flags_q[`ISR_EVT_EXE])
        else $error("Execution error lost.");

    a_cme_set: assert property ( // see R13
        command_error |=> event_flags_q[`ISR_EVT_CME])
        else $error("Command error lost.");

    a_pon_start: assert property ( // see R14
        $rose(reset_n) |-> event_flags_q[`ISR_EVT_PON])
        else $error("Power on flag absent after reset.");

    a_ese_store: assert property ( // see R15
        event_mask_wr |=> (event_mask_q == $past(event_mask_wdata)))
        else $error("Event mask not stored.");

    a_unused_zero: assert property ( // see R20
        ((event_flags_q & ~`ISR_EVT_USED) == 16'h0000)
        && ((status_poll_byte & 8'h8F) == 8'h00))
        else $error("Unused status or event bit set.");

    // A byte still in the FIFO must already count as available.
    a_mav_queued: assert property ( // see R01
        qif.pop_valid |=> status_poll_byte[`ISR_STB_MAV])
        else $error("Message available low while the queue holds data.");

    a_lost_flag: assert property ( // see R10
        data_lost |=> event_flags_q[`ISR_EVT_QYE])
        else $error("Lost queue data did not flag a query error.");

    // An unread byte must not move or change while the controller stalls.
    a_stage_hold: assert property ( // see R17
        (ov_reg && !resp_out_ready && !queue_flush) |=>
        (resp_out_valid && $stable(resp_out_data) && $stable(resp_out_end)))
        else $error("Output byte changed before it was read.");

    a_srq_masked: assert property ( // see R05
        ((sre_reg & `ISR_SRE_SUMMARY) == 8'h00) |=> !service_request)
        else $error("SRQ raised with every summary bit masked.");

    // Without arming, a clear completion flag stays clear.
    a_opc_quiet: assert property ( // see R09
        ((opc_reg == isr_pkg::ISR_OPC_IDLE) && !event_flags_q[`ISR_EVT_OPC])
        |=> !event_flags_q[`ISR_EVT_OPC])
        else $error("Operation complete set while not armed.");

    // Main scenarios that the bench is expected to reach.
    c_srq_raised: cover property ($rose(service_request));
    c_queue_full: cover property (!resp_in_ready);
    c_opc_done:   cover property (opc_done);
    c_data_lost:  cover property (data_lost);
    c_stage_stall: cover property (ov_reg && !resp_out_ready);
endmodule

// [rtl/isr_defs.svh]
// Bit positions, reset values and queue sizes of the status reporting block.
// Functional notes
// R01: Message available follows output queue occupancy.
// R02: Event summary ORs enabled event flags.
// R03: Service request sets request service bit.
// R04: Service request drives the SRQ line.
// R05: Eight-bit service request mask, controller writable.
// R06: Poll and query bit 6 always equal.
// R07: Master summary set on any enabled reason.
// R08: Poll and query return the same byte.
// R09: Operation complete only after arming, none pending.
// R10: Query error on empty read or lost data.
// R11: Device error flag for other errors.
// R12: Execution error flag for unexecutable valid commands.
// R13: Command error flag on syntax error.
// R14: Power on flag present after power-up.
// R15: Eight-bit event mask matches low event bits.
// R16: Responses and end markers enter the queue.
// R17: Queue holds bytes until read, then removes.
// R18: Controller serial-polls each instrument after SRQ.
// R19: Controller prefers status query outside interrupt handling.
// R20: Unused status and event bits read zero.
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH

// Status byte bit positions.
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_RQS 6
// Standard event bit positions.
`define ISR_EVT_OPC 0
`define ISR_EVT_QYE 2
`define ISR_EVT_DDE 3
`define ISR_EVT_EXE 4
`define ISR_EVT_CME 5
`define ISR_EVT_PON 7
// Bits that may ever be set; all others read as zero.
`define ISR_EVT_USED 16'h00BD
`define ISR_STB_USED 8'h70
// The request bit itself never takes part in the summary.
`define ISR_SRE_SUMMARY 8'hBF
// Reset values: masks cleared, power on flag present.
`define ISR_SRE_RESET 8'h00
`define ISR_ESE_RESET 8'h00
`define ISR_EVT_RESET 16'h0080
// Output queue: 32 entries of one data byte plus an end marker.
`define ISR_Q_DEPTH 32
`define ISR_Q_WIDTH 9

`endif

// [rtl/isr_pkg.sv]
// Types shared by the status reporting block.
package isr_pkg;
    // Operation complete monitor: idle until armed by the controller.
    typedef enum logic [1:0] {
        ISR_OPC_IDLE  = 2'b01,
        ISR_OPC_ARMED = 2'b10
    } isr_opc_state_t;
    // One output queue entry: end marker above the data byte.
    typedef logic [8:0] isr_entry_t;
endpackage

// [rtl/isr_queue_if.sv]
// Carrier between the status block and its output queue.
`timescale 1ns/1ps
interface isr_queue_if #(parameter int WIDTH = 9);
    logic             push_valid; // Formatter offers an entry.
    logic             push_ready; // Queue has room.
    logic [WIDTH-1:0] push_data;  // Entry being offered.
    logic             pop_valid;  // Queue holds an entry.
    logic             pop_ready;  // Reader takes the head entry.
    logic [WIDTH-1:0] pop_data;   // Head entry.
    logic             flush;      // Discard every entry.
    modport queue (input push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data);
    modport user  (output push_valid, push_data, pop_ready, flush,
                   input push_ready, pop_valid, pop_data);
endinterface

// [rtl/isr_fifo.sv]
// Output queue storage: a synchronous FIFO with registered flags.
`timescale 1ns/1ps
`include "isr_defs.svh"
module isr_fifo #(
    parameter int WIDTH = `ISR_Q_WIDTH,
    parameter int DEPTH = `ISR_Q_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    isr_queue_if.queue q
);
    // Pointers wrap by overflow, so the depth must be a power of two.
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Entry storage.
    logic [AW-1:0]    wr_ptr_reg;   // Next slot to fill.
    logic [AW-1:0]    rd_ptr_reg;   // Head slot.
    logic [AW:0]      count_reg;    // Entries held.
    logic [AW:0]      count_next;   // Entries held after this edge.
    logic             ready_reg;    // Room for one more.
    logic             valid_reg;    // At least one entry.

    wire push_fire = q.push_valid && ready_reg && !q.flush;
    wire pop_fire  = q.pop_ready && valid_reg && !q.flush;

    // A flush wins over a push in the same cycle; the caller counts that as loss.
    assign count_next = q.flush ? '0
                      : count_reg + (AW+1)'(push_fire) - (AW+1)'(pop_fire);
    assign q.push_ready = ready_reg;
    assign q.pop_valid  = valid_reg;
    assign q.pop_data   = mem[rd_ptr_reg];

    // Storage carries no reset; only pointers and flags define the content.
    always_ff @(posedge clk) begin
        if (push_fire) begin
            mem[wr_ptr_reg] <= q.push_data;
        end
    end

    // Pointers, count and the flags taken from the next count.
    always_ff @(posedge clk) begin
        if (!reset_n || q.flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= reset_n;
            valid_reg  <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push_fire);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop_fire);
            count_reg  <= count_next;
            ready_reg  <= count_next != (AW+1)'(DEPTH);
            valid_reg  <= count_next != '0;
        end
    end
endmodule

// [bench/isr_ctrl_model.sv]
// Controller-side model: reads the output queue and serial-polls on a service request.
`timescale 1ns/1ps
module isr_ctrl_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       take,
    input  wire logic       slow,
    input  wire logic       resp_out_valid,
    input  wire logic [7:0] resp_out_data,
    input  wire logic       resp_out_end,
    input  wire logic       service_request,
    input  wire logic [7:0] status_poll_byte,
    output logic            resp_out_ready
);
    isr_pkg::isr_entry_t got[$];     // Entries read so far, oldest first.
    logic [7:0]          poll_byte;  // Status byte seen by the last serial poll.

    initial resp_out_ready = 1'b0;

    // Reader: a slow controller stalls at random, which exercises the queue's hold path.
    always @(posedge clk) begin
        if (reset_n && resp_out_valid && resp_out_ready) begin
            got.push_back({resp_out_end, resp_out_data});
        end
        resp_out_ready <= take && (!slow || $urandom_range(2) != 0);
        // A request is answered by a poll; without one the model leaves the status byte unread.
        if (service_request) begin
            poll_byte <= status_poll_byte;
        end
    end
endmodule

// [bench/isr_status_tb.sv]
// Self-checking bench for the status reporting block.
`timescale 1ns/1ps
module isr_status_tb;
    logic clk = 1'b0, reset_n = 1'b0;
    logic sm_wr = 1'b0, em_wr = 1'b0, event_read = 1'b0, clear_status = 1'b0;
    logic opc_arm = 1'b0, ops_pending = 1'b0, dev_err = 1'b0, exe_err = 1'b0;
    logic cmd_err = 1'b0, resp_pending = 1'b0, queue_flush = 1'b0;
    logic in_valid = 1'b0, in_end = 1'b0, take = 1'b0, slow = 1'b0;
    logic [7:0] sm_wdata = 8'h00, em_wdata = 8'h00, in_data = 8'h00;
    logic in_ready, out_valid, out_end, out_ready, srq;
    logic [7:0] out_data, poll_b, query_b, sm_q, em_q;
    logic [15:0] flags, read_data;
    int fails = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    isr_status isr_status_i (
        .clk(clk), .reset_n(reset_n), .service_mask_wr(sm_wr),
        .service_mask_wdata(sm_wdata), .event_mask_wr(em_wr), .event_mask_wdata(em_wdata),
        .event_read(event_read), .clear_status(clear_status), .opc_arm(opc_arm),
        .ops_pending(ops_pending), .device_error(dev_err), .execution_error(exe_err),
        .command_error(cmd_err), .response_pending(resp_pending), .queue_flush(queue_flush),
        .resp_in_valid(in_valid), .resp_in_data(in_data), .resp_in_end(in_end),
        .resp_out_ready(out_ready), .resp_in_ready(in_ready), .resp_out_valid(out_valid),
        .resp_out_data(out_data), .resp_out_end(out_end), .service_request(srq),
        .status_poll_byte(poll_b), .status_query_byte(query_b), .service_mask_q(sm_q),
        .event_mask_q(em_q), .event_flags_q(flags), .event_read_data(read_data));

    isr_ctrl_model isr_ctrl_model_i (
        .clk(clk), .reset_n(reset_n), .take(take), .slow(slow),
        .resp_out_valid(out_valid), .resp_out_data(out_data), .resp_out_end(out_end),
        .service_request(srq), .status_poll_byte(poll_b), .resp_out_ready(out_ready));

    // Expected status byte; the request bit never feeds its own summary.
    function automatic logic [7:0] exp_stb(input logic [15:0] f, input logic [7:0] em,
                                           input logic [7:0] sm, input logic message_available_flag);
        logic [7:0] b;
        b = {2'b00, |(f[7:0] & em), message_available_flag, 4'h0};
        b[6] = |(b & sm & 8'hBF);
        return b;
    endfunction

    // Inputs move one nanosecond after the edge so no race with the design's flops.
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        fails++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        logic [7:0]          em, sm, e;
        logic [15:0]         f;
        int                  b, n;
        isr_pkg::isr_entry_t exp_q[$];
        void'($urandom(32'h8B9B70AD));
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        chk("flags", 16'h0080, flags);
        chk("stb", 16'h0000, {8'h00, query_b});
        // Random masks, each error kind in turn; the first three force a request.
        for (int i = 0; i < 9; i++) begin
            em = 8'($urandom);
            sm = 8'($urandom);
            if (i < 3) begin
                em[i+3] = 1'b1;
                sm[5] = 1'b1;
            end
            {sm_wr, sm_wdata, em_wr, em_wdata} = {1'b1, sm, 1'b1, em};
            f = flags;
            event_read = 1'b1;
            step();
            {sm_wr, em_wr, event_read} = 3'b000;
            chk("smask", {8'h00, sm}, {8'h00, sm_q});
            chk("emask", {8'h00, em}, {8'h00, em_q});
            chk("read", f, read_data);
            b = 3 + i % 3;
            {dev_err, exe_err, cmd_err} = {b == 3, b == 4, b == 5};
            step();
            {dev_err, exe_err, cmd_err} = 3'b000;
            chk("flags", 16'h0001 << b, flags);
            step();
            e = exp_stb(16'h0001 << b, em, sm, 1'b0);
            chk("poll", {8'h00, e}, {8'h00, poll_b});
            chk("query", {8'h00, e}, {8'h00, query_b});
            chk("srq", {15'h0000, e[6]}, {15'h0000, srq});
            step();
            if (e[6]) chk("spoll", {8'h00, e}, {8'h00, isr_ctrl_model_i.poll_byte});
        end
        // Completion monitor must stay quiet until armed.
        clear_status = 1'b1;
        step();
        clear_status = 1'b0;
        step(3);
        chk("opc", 16'h0000, flags);
        {ops_pending, opc_arm} = 2'b11;
        step();
        opc_arm = 1'b0;
        step(3);
        chk("opc", 16'h0000, flags);
        ops_pending = 1'b0;
        step(2);
        chk("opc", 16'h0001, flags);
        // Reads from an empty queue: excused while a response is pending.
        {resp_pending, take} = 2'b11;
        step(4);
        chk("qye", 16'h0001, flags);
        resp_pending = 1'b0;
        step(3);
        chk("qye", 16'h0005, flags);
        take = 1'b0;
        clear_status = 1'b1;
        step();
        clear_status = 1'b0;
        // Fill until refused while the controller stalls, then drain slowly.
        n = 0;
        in_valid = 1'b1;
        while (in_ready === 1'b1 && n < 40) begin
            in_data = 8'($urandom);
            in_end = 1'($urandom);
            exp_q.push_back({in_end, in_data});
            step();
            n++;
        end
        in_valid = 1'b0;
        step();
        chk("count", 16'h0021, n[15:0]);
        chk("mav", 16'h0001, {15'h0000, poll_b[4]});
        {slow, take} = 2'b11;
        for (int t = 0; t < 400 && isr_ctrl_model_i.got.size() < n; t++) step();
        foreach (exp_q[k]) chk("entry", {7'h00, exp_q[k]}, {7'h00, isr_ctrl_model_i.got[k]});
        step(2);
        chk("mav", 16'h0000, {15'h0000, poll_b[4]});
        // A flush that discards an unread byte counts as lost data.
        take = 1'b0;
        step();
        clear_status = 1'b1;
        step();
        {clear_status, in_valid, in_data} = {1'b0, 1'b1, 8'($urandom)};
        step();
        in_valid = 1'b0;
        step(2);
        chk("mav", 16'h0001, {15'h0000, poll_b[4]});
        queue_flush = 1'b1;
        step();
        queue_flush = 1'b0;
        step();
        chk("lost", 16'h0004, flags);
        chk("flushed", 16'h0000, {14'h0000, out_valid, poll_b[4]});
        wrap_up();
    end
endmodule
